//--- rbd_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rbd_chk
   import rbd_pkg::*;
#(parameter int COPY_WORDS = 8, parameter int ERASE_CYC = 20) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reset_in_n,
   input wire logic [15:0] boot_rdata,
   input wire rbd_copy_t boot_wr,
   input wire logic host_access_en,
   input wire logic [15:0] host_rdata,
   input wire logic busy_n,
   input wire logic irq_edge_mode,
   input wire logic irq_n
);
   localparam int BOOT_LIM = COPY_WORDS + ERASE_CYC + 10;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence pulse_s; !irq_n [*6] ##[1:11] irq_n; endsequence
   in_reset_a: assert property (!reset_in_n [*5] |-> !busy_n)
      else $error("busy not held in reset");
   copy_busy_a: assert property (boot_wr.valid |-> !host_access_en)
      else $error("copy while accepting");
   copy_order_a: assert property (boot_wr.valid && boot_wr.addr != 0 |->
      $past(boot_wr.valid) && $past(boot_wr.addr) == boot_wr.addr - 16'h1)
      else $error("copy out of order");
   ignore_host_a: assert property (!host_access_en |-> host_rdata == 0)
      else $error("data while busy");
   busy_match_a: assert property (host_access_en == busy_n)
      else $error("busy and access differ");
   release_bound_a: assert property ($rose(reset_in_n) |->
      ##[1:BOOT_LIM] busy_n) else $error("busy too long");
   data_ready_a: assert property ($rose(busy_n) |->
      ##[0:3] host_rdata == boot_rdata) else $error("no data");
   irq_width_a: assert property ($fell(irq_n) && irq_edge_mode |-> pulse_s)
      else $error("irq width");
endmodule
bind rbd_reset_boot rbd_chk #(.COPY_WORDS(COPY_WORDS),
   .ERASE_CYC(ERASE_CYC)) rbd_chk_inst (.sys_clk, .rst_n, .reset_in_n,
   .boot_rdata, .boot_wr, .host_access_en, .host_rdata, .busy_n,
   .irq_edge_mode, .irq_n);
`default_nettype wire

//--- rbd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rbd_host_model
   import rbd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic busy_n,
   output rbd_host_strb_t host_strb
);
   logic [2:0] seen_r;
   // first read waits on busy; chip enable kept past the release
   always_ff @(posedge sys_clk) begin
      seen_r <= rst_n ? {seen_r[1:0], busy_n} : 3'h0;
      host_strb <= &seen_r ? 3'h7 : 3'h1;
   end
endmodule
`default_nettype wire

//--- rbd_pkg.sv
package rbd_pkg;
   // clock
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   // time figures as printed
   localparam int BUSY_RELEASE_MAX_US_X10 = 13; // 1.3 ms, in tenths of ms
   localparam int ERASE_EXTEND_US = 500;
   localparam int IRQ_PULSE_MIN_NS = 300;
   localparam int IRQ_PULSE_MAX_NS = 800;
   localparam int ADDR_STROBE_HOLD_NS = 70;
   localparam int RESET_HOLD_US = 500;
   // derived cycle counts
   localparam int BOOT_MAX_CYC = BUSY_RELEASE_MAX_US_X10 * 100
      * (SYS_CLK_HZ / 1_000_000);
   localparam int ERASE_EXT_CYC = ERASE_EXTEND_US * (SYS_CLK_HZ / 1_000_000);
   localparam int IRQ_MIN_CYC = (IRQ_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int IRQ_MAX_CYC = IRQ_PULSE_MAX_NS / CLK_PERIOD_NS;
   // pulse length used: midway between bounds
   localparam int IRQ_PULSE_CYC = (IRQ_MIN_CYC + IRQ_MAX_CYC) / 2;
   // boot copy default length, well inside the bound
   localparam int BOOT_COPY_WORDS = 1024;
   // reset values
   localparam logic RST_BUSY_N = 1'b0;
   localparam logic RST_IRQ_N = 1'b1;

   typedef enum logic [1:0] {RBD_RESET, RBD_COPY, RBD_ERASE_WAIT,
      RBD_READY} rbd_state_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
   } rbd_host_strb_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [15:0] data;
   } rbd_copy_t;
endpackage

//--- rbd_reset_boot.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - device sits in reset while reset_in_n is low
// - reset release starts copying boot code from flash into boot block
// - host accesses are ignored while the boot copy runs
// - erase interrupted by reset may extend busy release by 500 us
// - read data valid by busy release; host keeps chip enable to then
// - edge-mode interrupt is one low pulse of 300 to 800 ns
module rbd_reset_boot
   import rbd_pkg::*;
#(
   parameter int COPY_WORDS = BOOT_COPY_WORDS,
   parameter int ERASE_CYC = ERASE_EXT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reset_in_n,
   input wire logic erase_active,
   input wire logic irq_event,
   input wire logic irq_edge_mode,
   input wire rbd_host_strb_t host_strb,
   input wire logic [15:0] flash_rdata,
   input wire logic [15:0] boot_rdata,
   output rbd_copy_t boot_wr,
   output logic [15:0] flash_addr,
   output logic host_access_en,
   output logic [15:0] host_rdata,
   output logic busy_n,
   output logic irq_n
);
   logic rin_sync_r;
   logic erase_sync_r;
   logic irq_mode_sync_r;
   rbd_host_strb_t strb_r;
   rbd_state_t state_r;
   logic [15:0] copy_cnt_r;
   logic [15:0] erase_cnt_r;
   logic erase_seen_r;
   logic [7:0] irq_cnt_r;
   logic irq_evt_sync_r, irq_evt_prev_r;

   // pins from the host side are asynchronous
   rbd_sync2 #(
      .W(1)
   ) rin_sync_inst (
      .sys_clk(sys_clk),
      .d(reset_in_n),
      .q(rin_sync_r)
   );

   rbd_sync2 #(
      .W(1)
   ) erase_sync_inst (
      .sys_clk(sys_clk),
      .d(erase_active),
      .q(erase_sync_r)
   );

   rbd_sync2 #(
      .W(3)
   ) strb_sync_inst (
      .sys_clk(sys_clk),
      .d(host_strb),
      .q(strb_r)
   );

   rbd_sync2 #(
      .W(1)
   ) irq_evt_sync_inst (
      .sys_clk(sys_clk),
      .d(irq_event),
      .q(irq_evt_sync_r)
   );

   // mode strap is a pin too; a change mid-pulse clears the count and irq_n then follows the event
   rbd_sync2 #(
      .W(1)
   ) irq_mode_sync_inst (
      .sys_clk(sys_clk),
      .d(irq_edge_mode),
      .q(irq_mode_sync_r)
   );

   // sequencing
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !rin_sync_r) begin
         state_r <= RBD_RESET;
      end else begin
         case (state_r)
            RBD_RESET: state_r <= RBD_COPY;
            RBD_COPY: begin
               if (copy_cnt_r == 16'(COPY_WORDS - 1)) begin
                  state_r <= erase_seen_r ? RBD_ERASE_WAIT : RBD_READY;
               end
            end
            RBD_ERASE_WAIT: begin
               if (erase_cnt_r == 16'(ERASE_CYC - 1)) begin
                  state_r <= RBD_READY;
               end
            end
            default: state_r <= RBD_READY;
         endcase
      end
   end

   // remember an erase cut short by reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         erase_seen_r <= 1'b0;
      end else if (!rin_sync_r) begin
         if (erase_sync_r) begin
            erase_seen_r <= 1'b1;
         end
      end else if (state_r == RBD_READY) begin
         erase_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_r == RBD_RESET) begin
         copy_cnt_r <= 16'h0000;
      end else if (state_r == RBD_COPY) begin
         copy_cnt_r <= copy_cnt_r + 16'h0001;
      end
   end

   // erase hold-off runs only once the copy is done
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_r == RBD_RESET) begin
         erase_cnt_r <= 16'h0000;
      end else if (state_r == RBD_ERASE_WAIT) begin
         erase_cnt_r <= erase_cnt_r + 16'h0001;
      end
   end

   // flash address leads write by one cycle: read latency of the array
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_r != RBD_COPY) begin
         flash_addr <= 16'h0000;
         boot_wr <= '0;
      end else begin
         flash_addr <= copy_cnt_r + 16'h0001;
         boot_wr.valid <= 1'b1;
         boot_wr.addr <= copy_cnt_r;
         boot_wr.data <= flash_rdata;
      end
   end

   // busy and access gate release together with data
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busy_n <= RST_BUSY_N;
      end else begin
         busy_n <= (state_r == RBD_READY) && rin_sync_r;
      end
   end

   // same term as busy, so the two can never disagree
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         host_access_en <= 1'b0;
      end else begin
         host_access_en <= (state_r == RBD_READY) && rin_sync_r;
      end
   end

   // read data set in the same cycle busy rises so a stretched read sees it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         host_rdata <= 16'h0000;
      end else if (state_r == RBD_READY && rin_sync_r && !strb_r.ce_n
            && !strb_r.oe_n) begin
         host_rdata <= boot_rdata;
      end else if (state_r != RBD_READY || !rin_sync_r) begin
         // cleared with the access gate, not a cycle later
         host_rdata <= 16'h0000;
      end
   end

   // tracks the pin in both modes: no stale edge after a mode change
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_r == RBD_RESET) begin
         irq_evt_prev_r <= 1'b0;
      end else begin
         irq_evt_prev_r <= irq_evt_sync_r;
      end
   end

   // edge mode: fixed-length low pulse; level mode follows the event
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_r == RBD_RESET) begin
         irq_n <= RST_IRQ_N;
         irq_cnt_r <= 8'h00;
      end else begin
         if (!irq_mode_sync_r) begin
            irq_n <= !irq_evt_sync_r;
            irq_cnt_r <= 8'h00;
         end else if (irq_cnt_r != 8'h00) begin
            irq_cnt_r <= irq_cnt_r - 8'h01;
            irq_n <= (irq_cnt_r == 8'h01);
         end else if (irq_evt_sync_r && !irq_evt_prev_r) begin
            irq_cnt_r <= 8'(IRQ_PULSE_CYC);
            irq_n <= 1'b0;
         end else begin
            irq_n <= 1'b1;
         end
      end
   end
endmodule

// two-flop synchroniser; only the second stage is seen outside
module rbd_sync2 #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge sys_clk) begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule
`default_nettype wire

//--- rbd_reset_boot_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rbd_reset_boot_tb;
   import rbd_pkg::*;
   localparam int CW = 8;
   localparam int EC = 20;
   logic sys_clk = 0, rst_n = 0, reset_in_n = 0, erase_active = 0;
   logic irq_event = 0, busy_n, irq_n, host_access_en;
   logic irq_edge_mode = 1, addr_valid_strobe_n = 0;
   logic [15:0] flash_addr, host_rdata;
   wire logic [15:0] flash_rdata;
   rbd_host_strb_t host_strb;
   rbd_copy_t boot_wr;
   int err_count = 0, checks = 0;
   always #25 sys_clk = ~sys_clk;
   // array answers the registered address within the same cycle
   assign flash_rdata = flash_addr ^ 16'ha5a5;
   rbd_reset_boot #(.COPY_WORDS(CW), .ERASE_CYC(EC)) rbd_reset_boot_inst (
      .sys_clk, .rst_n, .reset_in_n, .erase_active, .irq_event,
      .irq_edge_mode, .host_strb, .flash_rdata,
      .boot_rdata(16'h3c5a), .boot_wr, .flash_addr, .host_access_en,
      .host_rdata, .busy_n, .irq_n);
   rbd_host_model rbd_host_model_inst (.sys_clk, .rst_n, .busy_n,
      .host_strb);
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic boot(logic ers);
      int n, w;
      n = 0;
      w = 0;
      @(posedge sys_clk);
      reset_in_n <= 1'b0;
      addr_valid_strobe_n <= 1'b0;
      erase_active <= ers;
      repeat (12) @(posedge sys_clk);
      reset_in_n <= 1'b1;
      erase_active <= 1'b0;
      #1 cmp("busy_in_reset", 16'h0, 16'(busy_n));
      while (busy_n !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1 n++;
         if (boot_wr.valid === 1'b1) begin
            cmp("copy_addr", 16'(w), boot_wr.addr);
            cmp("copy_data", 16'(w) ^ 16'ha5a5, boot_wr.data);
            w++;
         end
         if (busy_n === 1'b0) cmp("rdata_busy", 16'h0, host_rdata);
      end
      addr_valid_strobe_n <= 1'b1;
      cmp("words", 16'(CW), 16'(w));
      cmp("in_time", 16'h1, 16'(n <= CW + 10 + (ers ? EC : 0)));
      repeat (4) @(posedge sys_clk);
      #1 cmp("first_read", 16'h3c5a, host_rdata);
   endtask
   task automatic irq_pulse();
      int lo;
      lo = 0;
      @(posedge sys_clk);
      irq_event <= 1'b1;
      repeat (30) begin
         @(posedge sys_clk);
         #1 lo += (irq_n === 1'b0);
      end
      irq_event <= 1'b0;
      cmp("irq_width", 16'h1, 16'(lo >= IRQ_MIN_CYC && lo <= IRQ_MAX_CYC));
   endtask
   task automatic irq_level();
      @(posedge sys_clk);
      irq_edge_mode <= 1'b0;
      irq_event <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 cmp("irq_level_on", 16'h0, 16'(irq_n));
      @(posedge sys_clk);
      irq_event <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 cmp("irq_level_off", 16'h1, 16'(irq_n));
      @(posedge sys_clk);
      irq_edge_mode <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
   initial begin
      #1ms err_count++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (RESET_HOLD_US * (SYS_CLK_HZ / 1_000_000)) @(posedge sys_clk);
      boot(1'b0);
      irq_pulse();
      irq_level();
      boot(1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
